// ===== common/stlc_defines.svh
// Offsets, masks, reset values and bit positions of the lane registers.
// Assumes a byte-addressed Avalon-MM slave with one 32-bit word per register.
`ifndef STLC_DEFINES_SVH
`define STLC_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define STLC_ADDR_W 5
`define STLC_OFF_SLEW 5'h00
`define STLC_OFF_LEVEL 5'h04
`define STLC_OFF_LANE 5'h08
`define STLC_OFF_PORT 5'h0C
`define STLC_OFF_STATUS 5'h10

// ****************************************
// Reset values and writable masks
// ****************************************
`define STLC_SLEW_RESET 32'h0802_0000
`define STLC_SLEW_MASK 32'h1FFF_0000
`define STLC_LEVEL_RESET 32'h8953_9791
`define STLC_LEVEL_MASK 32'hFFFF_FFFF
`define STLC_LANE_RESET 4'hF

// ****************************************
// Bit positions
// ****************************************
`define STLC_POS_LOW_SWING 0
`define STLC_POS_DEEMPH_SEL 1
`define STLC_POS_SLEW_OVR 26

`endif

// ===== common/stlc_pkg.sv
// Field layouts of the two lane control words and of one lane's drive.
// Assumes nothing beyond the defines header for its users.
package stlc_pkg;

  // ****************************************
  // Slew and boost word, one per lane
  // ****************************************
  typedef struct packed {
    logic [2:0] rsvd;
    logic [1:0] amplitude_boost;
    logic slew_ovr;
    logic [2:0] fine_slew_rate2;
    logic [1:0] coarse_slew_rate2;
    logic [2:0] fine_slew_rate1;
    logic [1:0] coarse_slew_rate1;
    logic [15:0] unused;
  } stlc_w0_s;

  // ****************************************
  // Level and de-emphasis word, one per lane
  // ****************************************
  typedef struct packed {
    logic [3:0] drive_level_low_rate2;
    logic [3:0] drive_level_low_rate1;
    logic [2:0] fine_deemph_full_rate2_strong;
    logic [4:0] drive_level_full_rate2_strong;
    logic [2:0] fine_deemph_full_rate2_mild;
    logic [4:0] drive_level_full_rate2_mild;
    logic [2:0] fine_deemph_full_rate1;
    logic [4:0] drive_level_full_rate1;
  } stlc_w1_s;

  // ****************************************
  // Effective settings sent to one driver
  // ****************************************
  typedef struct packed {
    logic slew_max;
    logic [1:0] coarse_slew;
    logic [2:0] fine_slew;
    logic [1:0] amp_boost;
    logic [4:0] level;
    logic deemph_en;
    logic [2:0] fine_deemph;
  } stlc_drive_s;

endpackage

// ===== dv/stlc_regs_bench.sv
// Self-checking bench for the lane tuning registers, driven over Avalon-MM.
// Assumes one core_clk, rstn as fundamental reset and all four lanes present.
`include "stlc_defines.svh"

module stlc_regs_bench;
  import stlc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Signals and design instance
  // ****************************************
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic port_rst = 1'b0;
  logic link_gen2 = 1'b0;
  logic [`STLC_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] tx_slew_max;
  logic [3:0][1:0] tx_coarse_slew;
  logic [3:0][2:0] tx_fine_slew;
  logic [3:0][1:0] tx_amp_boost;
  logic [3:0][4:0] tx_level;
  logic [3:0] tx_deemph_en;
  logic [3:0][2:0] tx_fine_deemph;
  logic [31:0] rd;
  int num_errors = 0;
  int checks_done = 0;

  always #2.5 core_clk = ~core_clk;

  stlc_regs #(.NUM_LANES(4)) stlc_regs_inst (
    .core_clk(core_clk), .rstn(rstn), .port_rst(port_rst), .link_gen2(link_gen2),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_slew_max(tx_slew_max), .tx_coarse_slew(tx_coarse_slew), .tx_fine_slew(tx_fine_slew),
    .tx_amp_boost(tx_amp_boost), .tx_level(tx_level), .tx_deemph_en(tx_deemph_en),
    .tx_fine_deemph(tx_fine_deemph)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Master holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // The wait ends once waitrequest is sampled low; there is no timeout here other than the watchdog
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, rd);
    check(rd, exp);
  endtask

  // Outputs lag stored state one edge; reads at an edge see what stood before it
  task automatic settle();
    repeat (2) @(posedge core_clk);
  endtask

  task automatic chk_lane(input int l, input logic [16:0] exp);
    check(32'({tx_slew_max[l], tx_coarse_slew[l], tx_fine_slew[l], tx_amp_boost[l], tx_level[l],
               tx_deemph_en[l], tx_fine_deemph[l]}), 32'(exp));
  endtask

  function automatic logic [16:0] drv(input logic mx, input logic [1:0] c, input logic [2:0] f,
                                      input logic [1:0] b, input logic [4:0] lv, input logic e,
                                      input logic [2:0] fd);
    return {mx, c, f, b, lv, e, fd};
  endfunction

  task automatic fund_reset();
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
  endtask

  // ****************************************
  // Watchdog, far above the expected span
  // ****************************************
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    end_of_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  typedef struct packed {
    logic g2;
    logic [1:0] port;
    logic [4:0] lv;
    logic en;
    logic [2:0] fd;
  } stlc_case_s;
  stlc_case_s cases [5] = '{
    '{1'b0, 2'b00, 5'h0C, 1'b1, 3'h6}, '{1'b1, 2'b10, 5'h15, 1'b1, 3'h3},
    '{1'b1, 2'b00, 5'h0A, 1'b1, 3'h5}, '{1'b0, 2'b11, 5'h03, 1'b0, 3'h0},
    '{1'b1, 2'b01, 5'h06, 1'b0, 3'h0}};

  initial begin
    fund_reset();
    settle();
    chk_lane(0, drv(1'b0, 2'h2, 3'h0, 2'h1, 5'h11, 1'b1, 3'h4));
    rd_chk(`STLC_OFF_STATUS, 32'(drv(1'b0, 2'h2, 3'h0, 2'h1, 5'h11, 1'b1, 3'h4)));
    rd_chk(`STLC_OFF_SLEW, 32'h0802_0000);
    rd_chk(`STLC_OFF_LEVEL, 32'h8953_9791);
    wr(`STLC_OFF_SLEW, 32'hFFFF_FFFF);
    rd_chk(`STLC_OFF_SLEW, 32'h1FFF_0000);
    settle();
    chk_lane(3, drv(1'b1, 2'h0, 3'h0, 2'h3, 5'h11, 1'b1, 3'h4));
    link_gen2 <= 1'b1;
    settle();
    chk_lane(2, drv(1'b1, 2'h0, 3'h0, 2'h3, 5'h13, 1'b1, 3'h2));
    wr(`STLC_OFF_SLEW, 32'h12AF_0000);
    settle();
    chk_lane(1, drv(1'b0, 2'h1, 3'h5, 2'h2, 5'h13, 1'b1, 3'h2));
    // Table sweeps rate, swing and de-emphasis choice
    wr(`STLC_OFF_LEVEL, 32'h63AA_75CC);
    foreach (cases[i]) begin
      link_gen2 <= cases[i].g2;
      wr(`STLC_OFF_PORT, 32'({cases[i].port}));
      settle();
      check(32'({tx_level[0], tx_deemph_en[0], tx_fine_deemph[0]}),
            32'({cases[i].lv, cases[i].en, cases[i].fd}));
    end
    link_gen2 <= 1'b0;
    // Only lane 1 takes the next write
    wr(`STLC_OFF_LANE, 32'h0000_0002);
    wr(`STLC_OFF_SLEW, 32'h0000_0000);
    settle();
    check(32'(tx_amp_boost[1]), 32'h0000_0000);
    check(32'(tx_amp_boost[0]), 32'h0000_0002);
    check(32'(tx_coarse_slew[2]), 32'h0000_0003);
    rd_chk(`STLC_OFF_SLEW, 32'h0000_0000);
    // Port reset keeps lane words, selects all lanes again and clears the port bits
    @(posedge core_clk);
    port_rst <= 1'b1;
    @(posedge core_clk);
    port_rst <= 1'b0;
    settle();
    check(32'(tx_amp_boost[1]), 32'h0000_0000);
    check(32'(tx_amp_boost[0]), 32'h0000_0002);
    rd_chk(`STLC_OFF_LANE, 32'h0000_000F);
    rd_chk(`STLC_OFF_PORT, 32'h0000_0000);
    rd_chk(`STLC_OFF_SLEW, 32'h12AF_0000);
    rd_chk(`STLC_OFF_LEVEL, 32'h63AA_75CC);
    // Unmapped place reads zero and ignores writes
    wr(5'h14, 32'hFFFF_FFFF);
    rd_chk(5'h14, 32'h0000_0000);
    // Fundamental reset returns defaults
    fund_reset();
    settle();
    rd_chk(`STLC_OFF_SLEW, 32'h0802_0000);
    rd_chk(`STLC_OFF_LEVEL, 32'h8953_9791);
    chk_lane(1, drv(1'b0, 2'h2, 3'h0, 2'h1, 5'h11, 1'b1, 3'h4));
    end_of_test();
  end

endmodule // stlc_regs_bench

// ===== rtl/stlc_lane_drive.sv
// Picks one lane's effective driver settings from its two stored words.
// Assumes rate, swing mode and de-emphasis select are stable core_clk levels.
module stlc_lane_drive (
  input stlc_pkg::stlc_w0_s w0,
  input stlc_pkg::stlc_w1_s w1,
  input logic gen2,
  input logic low_swing,
  input logic deemph_sel,
  output stlc_pkg::stlc_drive_s drive
);
  import stlc_pkg::*;

  // ****************************************
  // Setting selection
  // ****************************************
  always_comb begin
    drive = '0;
    drive.amp_boost = w0.amplitude_boost;
    if (w0.slew_ovr) begin
      drive.slew_max = 1'b1;
    end else if (gen2) begin
      drive.coarse_slew = w0.coarse_slew_rate2;
      drive.fine_slew = w0.fine_slew_rate2;
    end else begin
      drive.coarse_slew = w0.coarse_slew_rate1;
      drive.fine_slew = w0.fine_slew_rate1;
    end
    if (low_swing) begin
      // No de-emphasis in low swing, fine setting ignored
      drive.level = gen2 ? {1'b0, w1.drive_level_low_rate2} : {1'b0, w1.drive_level_low_rate1};
    end else if (!gen2) begin
      drive.level = w1.drive_level_full_rate1;
      drive.deemph_en = 1'b1;
      drive.fine_deemph = w1.fine_deemph_full_rate1;
    end else if (deemph_sel) begin
      drive.level = w1.drive_level_full_rate2_mild;
      drive.deemph_en = 1'b1;
      drive.fine_deemph = w1.fine_deemph_full_rate2_mild;
    end else begin
      drive.level = w1.drive_level_full_rate2_strong;
      drive.deemph_en = 1'b1;
      drive.fine_deemph = w1.fine_deemph_full_rate2_strong;
    end
  end

endmodule // stlc_lane_drive

// ===== rtl/stlc_regs.sv
// Per-lane transmitter tuning registers behind an Avalon-MM slave.
// Assumes link_gen2 and port_rst come from logic on core_clk; rstn is fundamental reset.
//
// How it works
// - Fine rate-2 slew, bits 25:23, reset zero
// - Override bit 26 forces maximum slew
// - Amplitude boost bits 28:27, reset one
// - Rate-1 full-swing level bits 4:0, 0x11
// - Rate-1 fine de-emphasis bits 7:5, reset 4
// - Low swing ignores fine de-emphasis
// - Rate-2 mild level bits 12:8, 0x17
// - Writes reach only lanes in lane_select
// - Unselected lanes keep their stored settings
// - Low swing when low_swing_enable is one
// - deemphasis_select picks mild or strong fields
`include "stlc_defines.svh"

module stlc_regs #(
  parameter int NUM_LANES = 4
) (
  input logic core_clk,
  input logic rstn,
  input logic port_rst,
  input logic link_gen2,
  input logic [`STLC_ADDR_W-1:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [NUM_LANES-1:0] tx_slew_max,
  output logic [NUM_LANES-1:0][1:0] tx_coarse_slew,
  output logic [NUM_LANES-1:0][2:0] tx_fine_slew,
  output logic [NUM_LANES-1:0][1:0] tx_amp_boost,
  output logic [NUM_LANES-1:0][4:0] tx_level,
  output logic [NUM_LANES-1:0] tx_deemph_en,
  output logic [NUM_LANES-1:0][2:0] tx_fine_deemph
);
  import stlc_pkg::*;

  localparam int LW = (NUM_LANES > 1) ? $clog2(NUM_LANES) : 1;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    stlc_w0_s [NUM_LANES-1:0] w0;
    stlc_w1_s [NUM_LANES-1:0] w1;
    stlc_drive_s [NUM_LANES-1:0] drive;
    logic [NUM_LANES-1:0] lane_select;
    logic low_swing_enable;
    logic deemphasis_select;
    logic waitreq;
    logic [31:0] rdata;
  } stlc_state_s;

  stlc_state_s state_reg;
  stlc_state_s state_next;
  stlc_drive_s [NUM_LANES-1:0] drive_sel;
  logic [LW-1:0] read_lane;
  logic write_go;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r & mask;
  endfunction

  // Lowest selected lane answers reads; lane 0 when none
  function automatic logic [LW-1:0] first_lane(input logic [NUM_LANES-1:0] sel);
    logic [LW-1:0] f;
    f = '0;
    for (int i = NUM_LANES - 1; i >= 0; i--) begin
      if (sel[i]) begin
        f = LW'(i);
      end
    end
    return f;
  endfunction

  // ****************************************
  // Per-lane setting selection
  // ****************************************
  for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
    stlc_lane_drive u_drive (
      .w0(state_reg.w0[g]),
      .w1(state_reg.w1[g]),
      .gen2(link_gen2),
      .low_swing(state_reg.low_swing_enable),
      .deemph_sel(state_reg.deemphasis_select),
      .drive(drive_sel[g])
    );
    assign tx_slew_max[g] = state_reg.drive[g].slew_max;
    assign tx_coarse_slew[g] = state_reg.drive[g].coarse_slew;
    assign tx_fine_slew[g] = state_reg.drive[g].fine_slew;
    assign tx_amp_boost[g] = state_reg.drive[g].amp_boost;
    assign tx_level[g] = state_reg.drive[g].level;
    assign tx_deemph_en[g] = state_reg.drive[g].deemph_en;
    assign tx_fine_deemph[g] = state_reg.drive[g].fine_deemph;
  end

  assign avs_readdata = state_reg.rdata;
  assign avs_waitrequest = state_reg.waitreq;
  assign read_lane = first_lane(state_reg.lane_select);
  assign write_go = avs_write && !state_reg.waitreq;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.waitreq = 1'b1;
    // One wait cycle per access keeps read data a flop output
    if ((avs_read || avs_write) && state_reg.waitreq) begin
      state_next.waitreq = 1'b0;
      state_next.rdata = '0;
      if (avs_read) begin
        if (avs_address == `STLC_OFF_SLEW) begin
          state_next.rdata = state_reg.w0[read_lane] & `STLC_SLEW_MASK;
        end else if (avs_address == `STLC_OFF_LEVEL) begin
          state_next.rdata = state_reg.w1[read_lane];
        end else if (avs_address == `STLC_OFF_LANE) begin
          state_next.rdata = 32'(state_reg.lane_select);
        end else if (avs_address == `STLC_OFF_PORT) begin
          state_next.rdata[`STLC_POS_LOW_SWING] = state_reg.low_swing_enable;
          state_next.rdata[`STLC_POS_DEEMPH_SEL] = state_reg.deemphasis_select;
        end else if (avs_address == `STLC_OFF_STATUS) begin
          state_next.rdata = 32'(state_reg.drive[read_lane]);
        end
      end
    end
    if (write_go) begin
      if (avs_address == `STLC_OFF_SLEW) begin
        for (int i = 0; i < NUM_LANES; i++) begin
          if (state_reg.lane_select[i]) begin
            state_next.w0[i] = stlc_w0_s'(merge(state_reg.w0[i], avs_writedata, avs_byteenable,
                                                `STLC_SLEW_MASK));
          end
        end
      end else if (avs_address == `STLC_OFF_LEVEL) begin
        for (int i = 0; i < NUM_LANES; i++) begin
          if (state_reg.lane_select[i]) begin
            state_next.w1[i] = stlc_w1_s'(merge(state_reg.w1[i], avs_writedata, avs_byteenable,
                                                `STLC_LEVEL_MASK));
          end
        end
      end else if (avs_address == `STLC_OFF_LANE) begin
        if (avs_byteenable[0]) begin
          state_next.lane_select = avs_writedata[NUM_LANES-1:0];
        end
      end else if (avs_address == `STLC_OFF_PORT) begin
        if (avs_byteenable[0]) begin
          state_next.low_swing_enable = avs_writedata[`STLC_POS_LOW_SWING];
          state_next.deemphasis_select = avs_writedata[`STLC_POS_DEEMPH_SEL];
        end
      end
    end
    // Port reset returns control to defaults only (lane_select loads STLC_LANE_RESET, port bits zero); lane words are sticky
    if (port_rst) begin
      state_next.lane_select = NUM_LANES'(`STLC_LANE_RESET);
      state_next.low_swing_enable = 1'b0;
      state_next.deemphasis_select = 1'b0;
    end
    state_next.drive = drive_sel;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg.w0 <= {NUM_LANES{`STLC_SLEW_RESET}};
      state_reg.w1 <= {NUM_LANES{`STLC_LEVEL_RESET}};
      state_reg.drive <= '0;
      state_reg.lane_select <= NUM_LANES'(`STLC_LANE_RESET);
      state_reg.low_swing_enable <= 1'b0;
      state_reg.deemphasis_select <= 1'b0;
      state_reg.waitreq <= 1'b1;
      state_reg.rdata <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_lane0_write(logic [`STLC_ADDR_W-1:0] off);
    write_go && avs_address == off && avs_byteenable == 4'hF;
  endsequence

  // Sampled rstn skips the release edge, outputs still zero there
  sequence s_full_rate1;
    rstn && !state_reg.low_swing_enable && !link_gen2 && $stable(link_gen2);
  endsequence

  sequence s_read_taken(logic [`STLC_ADDR_W-1:0] off);
    avs_read && avs_waitrequest && avs_address == off;
  endsequence

  property p_fine_slew_rate2;
    (rstn && link_gen2 && !state_reg.w0[0].slew_ovr)
      |=> tx_fine_slew[0] == $past(state_reg.w0[0].fine_slew_rate2);
  endproperty
  a_fine_slew_rate2: assert property (p_fine_slew_rate2) else $error("fine slew rate2 wrong");

  property p_slew_override;
    rstn && state_reg.w0[0].slew_ovr
      |=> tx_slew_max[0] && tx_coarse_slew[0] == 2'h0 && tx_fine_slew[0] == 3'h0;
  endproperty
  a_slew_override: assert property (p_slew_override) else $error("slew override ignored");

  property p_amp_boost;
    s_lane0_write(`STLC_OFF_SLEW) ##0 state_reg.lane_select[0]
      ##2 1'b1 |-> tx_amp_boost[0] == $past(avs_writedata[28:27], 2);
  endproperty
  a_amp_boost: assert property (p_amp_boost) else $error("boost not applied");

  property p_level_rate1;
    s_full_rate1 |=> tx_level[0] == $past(state_reg.w1[0].drive_level_full_rate1);
  endproperty
  a_level_rate1: assert property (p_level_rate1) else $error("rate1 level wrong");

  property p_deemph_rate1;
    s_full_rate1 |=> tx_deemph_en[0] && tx_fine_deemph[0] == $past(state_reg.w1[0].fine_deemph_full_rate1);
  endproperty
  a_deemph_rate1: assert property (p_deemph_rate1) else $error("rate1 de-emphasis wrong");

  property p_low_swing_deemph;
    state_reg.low_swing_enable |=> !tx_deemph_en[0] && tx_fine_deemph[0] == 3'h0;
  endproperty
  a_low_swing_deemph: assert property (p_low_swing_deemph) else $error("de-emphasis in low swing");

  property p_level_rate2_sel;
    (rstn && !state_reg.low_swing_enable && link_gen2)
      |=> tx_level[0] == ($past(state_reg.deemphasis_select)
                          ? $past(state_reg.w1[0].drive_level_full_rate2_mild)
                          : $past(state_reg.w1[0].drive_level_full_rate2_strong));
  endproperty
  a_level_rate2_sel: assert property (p_level_rate2_sel) else $error("rate2 level select wrong");

  property p_unselected_kept;
    (write_go && !state_reg.lane_select[0]) |=> $stable(state_reg.w0[0]) && $stable(state_reg.w1[0]);
  endproperty
  a_unselected_kept: assert property (p_unselected_kept) else $error("unselected lane written");

  property p_low_swing_write;
    s_lane0_write(`STLC_OFF_PORT) ##0 !port_rst
      |=> state_reg.low_swing_enable == $past(avs_writedata[`STLC_POS_LOW_SWING]);
  endproperty
  a_low_swing_write: assert property (p_low_swing_write) else $error("low swing enable lost");

  property p_sticky_port_rst;
    (port_rst && !write_go) |=> $stable(state_reg.w0) && $stable(state_reg.w1)
                                && state_reg.lane_select == `STLC_LANE_RESET;
  endproperty
  a_sticky_port_rst: assert property (p_sticky_port_rst) else $error("sticky field disturbed");

  property p_reserved_zero;
    (avs_read && avs_address == `STLC_OFF_SLEW && !avs_waitrequest) |-> avs_readdata[31:29] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_wait_one;
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest timing wrong");

  property p_read_level;
    s_read_taken(`STLC_OFF_LEVEL) |=> avs_readdata == $past(state_reg.w1[read_lane]);
  endproperty
  a_read_level: assert property (p_read_level) else $error("level word readback wrong");

  property p_status_read;
    s_read_taken(`STLC_OFF_STATUS) |=> avs_readdata == 32'($past(state_reg.drive[read_lane]));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status readback wrong");

  property p_unmapped_read;
    (avs_read && avs_waitrequest && avs_address > `STLC_OFF_STATUS) |=> avs_readdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_slew_word_write;
    s_lane0_write(`STLC_OFF_SLEW) ##0 state_reg.lane_select[0]
      |=> state_reg.w0[0] == ($past(avs_writedata) & `STLC_SLEW_MASK);
  endproperty
  a_slew_word_write: assert property (p_slew_word_write) else $error("slew word write lost");

  property p_level_word_write;
    s_lane0_write(`STLC_OFF_LEVEL) ##0 state_reg.lane_select[0]
      |=> state_reg.w1[0] == $past(avs_writedata);
  endproperty
  a_level_word_write: assert property (p_level_word_write) else $error("level word write lost");

  property p_lane_select_write;
    s_lane0_write(`STLC_OFF_LANE) ##0 !port_rst
      |=> state_reg.lane_select == $past(avs_writedata[NUM_LANES-1:0]);
  endproperty
  a_lane_select_write: assert property (p_lane_select_write) else $error("lane select write lost");

  property p_deemph_sel_write;
    s_lane0_write(`STLC_OFF_PORT) ##0 !port_rst
      |=> state_reg.deemphasis_select == $past(avs_writedata[`STLC_POS_DEEMPH_SEL]);
  endproperty
  a_deemph_sel_write: assert property (p_deemph_sel_write) else $error("de-emphasis select lost");

  property p_port_rst_clears;
    port_rst |=> !state_reg.low_swing_enable && !state_reg.deemphasis_select;
  endproperty
  a_port_rst_clears: assert property (p_port_rst_clears) else $error("port reset left mode bits");

  property p_boost_follows;
    rstn |=> tx_amp_boost[0] == $past(state_reg.w0[0].amplitude_boost);
  endproperty
  a_boost_follows: assert property (p_boost_follows) else $error("boost output stale");

  property p_low_swing_level;
    (rstn && state_reg.low_swing_enable)
      |=> tx_level[0] == ($past(link_gen2) ? {1'b0, $past(state_reg.w1[0].drive_level_low_rate2)}
                                           : {1'b0, $past(state_reg.w1[0].drive_level_low_rate1)});
  endproperty
  a_low_swing_level: assert property (p_low_swing_level) else $error("low swing level wrong");

  property p_rate1_slew;
    (rstn && !link_gen2 && !state_reg.w0[0].slew_ovr)
      |=> !tx_slew_max[0] && tx_fine_slew[0] == $past(state_reg.w0[0].fine_slew_rate1);
  endproperty
  a_rate1_slew: assert property (p_rate1_slew) else $error("rate2 fine slew used at rate1");

endmodule // stlc_regs
